/* File: rtl/scl_cfg.svh */
/*
 constants for the serial control word loader: word layout, frame length, fifo size.
 assumes inclusion by bare name from rtl files.
*/
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH
`define SCL_WORD_BITS 16
`define SCL_CTRL_MSB 15
`define SCL_CTRL_LSB 12
`define SCL_ADDR_MSB 11
`define SCL_ADDR_LSB 8
`define SCL_DATA_MSB 7
`define SCL_DATA_LSB 0
`define SCL_CNT_BITS 5
`define SCL_LAST_BIT 5'h0F
`define SCL_CNT_ZERO 5'h00
`define SCL_CNT_ONE 5'h01
`define SCL_FIFO_DEPTH 16
`define SCL_SCLK_MAX_MHZ 40
`define SCL_SYS_MHZ 100
`endif

/* File: rtl/scl_fifo.sv */
/*
 synchronous fifo with valid/ready on both sides.
 assumes a single clock; DEPTH is a power of two.
*/
`timescale 1ns/1ns
module scl_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] wp_nxt;
   logic [AW:0] rp_r;
   logic [AW:0] rp_nxt;
   logic full;
   logic empty;
   logic push;
   logic pop;
   always_comb begin
      full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
      empty = (wp_r == rp_r);
      push = in_valid && !full;
      pop = out_ready && !empty;
      wp_nxt = push ? wp_r + (AW+1)'(1) : wp_r;
      rp_nxt = pop ? rp_r + (AW+1)'(1) : rp_r;
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end
   // storage carries no reset so it can map to ram
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= in_data;
      end
   end
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_r[rp_r[AW-1:0]];
endmodule // scl_fifo

/* File: rtl/scl_loader.sv */
/*
 serial control word loader: three-wire write-only receiver, 16-bit words,
 msb first, sampled on falling shift-clock edges, words queued in a fifo.
 assumes sys_clk at 100 MHz; the shift clock is oversampled, so each of its
 levels must last two sys_clk periods, which caps the link well below 40 MHz.
 a registered queue head adds one word of room beyond the fifo depth.
*/
`timescale 1ns/1ns
`include "scl_cfg.svh"
module scl_loader
   import scl_pkg::*;
#(
   parameter int FIFO_DEPTH = `SCL_FIFO_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // link pins
   input wire scl_pkg::scl_pins_type pins,
   // immediate word strobe
   output scl_pkg::scl_word_type word_out,
   output logic word_strobe,
   // queued words
   output scl_pkg::scl_word_type q_data,
   output logic q_valid,
   input wire logic q_ready,
   // status
   output logic overflow,
   output logic frame_busy
);
   import scl_pkg::*;
   // ****************************************
   // pin conditioning
   // ****************************************
   logic [2:0] lvl;
   logic sclk_prev_r;
   logic sclk_prev_nxt;
   logic fall;
   logic fs_n;
   logic sdi;
   scl_sync #(
      .WIDTH(3)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_in({pins.shift_clk, pins.frame_select_n, pins.serial_data_in}),
      .level_out(lvl)
   );
   always_comb begin
      sclk_prev_nxt = lvl[2];
      fs_n = lvl[1];
      sdi = lvl[0];
      fall = sclk_prev_r && !lvl[2];
   end
   // ****************************************
   // frame and shift state
   // ****************************************
   scl_state_type st_r;
   scl_state_type st_nxt;
   logic [`SCL_CNT_BITS-1:0] cnt_r;
   logic [`SCL_CNT_BITS-1:0] cnt_nxt;
   logic [`SCL_WORD_BITS-1:0] sh_r;
   logic [`SCL_WORD_BITS-1:0] sh_nxt;
   logic done;
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      done = 1'b0;
      case (st_r)
         SCL_IDLE: begin
            cnt_nxt = `SCL_CNT_ZERO;
            if (!fs_n) begin
               st_nxt = SCL_SHIFT;
               if (fall) begin
                  sh_nxt = {sh_r[`SCL_WORD_BITS-2:0], sdi};
                  cnt_nxt = `SCL_CNT_ONE;
               end
            end
         end
         SCL_SHIFT: begin
            if (fs_n) begin
               st_nxt = SCL_IDLE;
               cnt_nxt = `SCL_CNT_ZERO;
            end else if (fall) begin
               sh_nxt = {sh_r[`SCL_WORD_BITS-2:0], sdi};
               if (cnt_r == `SCL_LAST_BIT) begin
                  done = 1'b1;
                  st_nxt = SCL_DROP;
               end else begin
                  cnt_nxt = cnt_r + `SCL_CNT_ONE;
               end
            end
         end
         SCL_DROP: begin
            // extra edges ignored until frame ends
            cnt_nxt = `SCL_CNT_ZERO;
            if (fs_n) begin
               st_nxt = SCL_IDLE;
            end
         end
         default: begin
            st_nxt = SCL_IDLE;
            cnt_nxt = `SCL_CNT_ZERO;
         end
      endcase
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= SCL_IDLE;
         cnt_r <= `SCL_CNT_ZERO;
         sh_r <= '0;
         sclk_prev_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         sclk_prev_r <= sclk_prev_nxt;
      end
   end
   // ****************************************
   // word delivery
   // ****************************************
   scl_word_type word_r;
   scl_word_type word_nxt;
   logic strobe_r;
   logic strobe_nxt;
   logic ovf_r;
   logic ovf_nxt;
   logic busy_r;
   logic busy_nxt;
   logic push_ready;
   scl_word_type fifo_in;
   scl_word_type fifo_out;
   logic fifo_valid;
   logic [`SCL_WORD_BITS-1:0] fifo_out_raw;
   scl_word_type head_r;
   scl_word_type head_nxt;
   logic head_valid_r;
   logic head_valid_nxt;
   logic head_load;
   always_comb begin
      fifo_in = scl_word_type'({sh_r[`SCL_WORD_BITS-2:0], sdi});
      word_nxt = word_r;
      strobe_nxt = done;
      // a full queue cannot stall a serial host, so the word is lost and flagged
      ovf_nxt = ovf_r | (done & !push_ready);
      busy_nxt = (st_nxt == SCL_SHIFT);
      if (done) begin
         word_nxt = fifo_in;
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         word_r <= '0;
         strobe_r <= 1'b0;
         ovf_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         word_r <= word_nxt;
         strobe_r <= strobe_nxt;
         ovf_r <= ovf_nxt;
         busy_r <= busy_nxt;
      end
   end
   scl_fifo #(
      .WIDTH(`SCL_WORD_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(done),
      .in_ready(push_ready),
      .in_data(fifo_in),
      .out_valid(fifo_valid),
      .out_ready(head_load),
      .out_data(fifo_out_raw)
   );
   assign fifo_out = scl_word_type'(fifo_out_raw);
   // ****************************************
   // registered queue head
   // ****************************************
   // the head register keeps q_data and q_valid on flops instead of the ram read;
   // it refills whenever it is empty or being drained, so no bubble is added
   always_comb begin
      head_load = fifo_valid && (!head_valid_r || q_ready);
      head_nxt = head_r;
      head_valid_nxt = head_valid_r && !q_ready;
      if (head_load) begin
         head_nxt = fifo_out;
         head_valid_nxt = 1'b1;
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         head_r <= '0;
         head_valid_r <= 1'b0;
      end else begin
         head_r <= head_nxt;
         head_valid_r <= head_valid_nxt;
      end
   end
   assign word_out = word_r;
   assign word_strobe = strobe_r;
   assign overflow = ovf_r;
   assign frame_busy = busy_r;
   assign q_valid = head_valid_r;
   assign q_data = head_r;
endmodule // scl_loader

/* File: rtl/scl_pkg.sv */
/*
 types of the serial control word loader.
 assumes scl_cfg.svh is reachable on the include path.
*/
`include "scl_cfg.svh"
package scl_pkg;
   // decoded word: control nibble, register address, data byte
   typedef struct packed {
      logic [`SCL_CTRL_MSB-`SCL_CTRL_LSB:0] ctrl;
      logic [`SCL_ADDR_MSB-`SCL_ADDR_LSB:0] addr;
      logic [`SCL_DATA_MSB-`SCL_DATA_LSB:0] data;
   } scl_word_type;
   // raw link pins
   typedef struct packed {
      logic shift_clk;
      logic frame_select_n;
      logic serial_data_in;
   } scl_pins_type;
   typedef enum logic [1:0] {
      SCL_IDLE,
      SCL_SHIFT,
      SCL_DROP
   } scl_state_type;
endpackage

/* File: rtl/scl_sync.sv */
/*
 three-stage synchroniser for the link pins with a second/third agreement filter.
 assumes pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ns
module scl_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // pins in, filtered level out
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] lvl_r;
   logic [WIDTH-1:0] lvl_nxt;
   // ****************************************
   // agreement filter, one generate per pin
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_comb begin
            lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
         end
      end
   endgenerate
   // pins idle high: frame inactive, clock resting high
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_r <= {WIDTH{1'b1}};
         s2_r <= {WIDTH{1'b1}};
         s3_r <= {WIDTH{1'b1}};
         lvl_r <= {WIDTH{1'b1}};
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end
   assign level_out = lvl_r;
endmodule // scl_sync

/* File: verif/scl_host_model.sv */
/*
 host model driving the three link pins one frame at a time.
 assumes the bench calls xfer and nothing else drives the pins.
*/
`timescale 1ns/1ns
module scl_host_model (
   // link pins
   output logic shift_clk,
   output logic frame_select_n,
   output logic serial_data_in
);
   initial begin
      shift_clk = 1'h1;
      frame_select_n = 1'h1;
      serial_data_in = 1'h0;
   end
   // ****
   // frame transfer
   // ****
   task automatic xfer(input logic [15:0] w, input int nb, input int sp, input logic rl);
      // active-low frame held over the word
      frame_select_n = 1'h0;
      for (int i = 0; i < nb; i++) begin
         // 80 ns clock, data moves on the rise, msb first
         shift_clk = 1'h1;
         serial_data_in = w[4'(15 - i)];
         #40;
         shift_clk = 1'h0;
         #40;
         // byte pause, frame low, clock parked high
         if (i == sp - 1) begin
            shift_clk = 1'h1;
            #400;
         end
      end
      // frame rises after the last bit; data is no longer held
      shift_clk = 1'h1;
      serial_data_in = ~serial_data_in;
      #40;
      frame_select_n = 1'h1;
      #40;
      // clock stops at the chosen rest level between frames
      shift_clk = rl;
      #40;
   endtask
endmodule // scl_host_model

/* File: verif/scl_loader_assertions.sv */
/*
 checker on the loader's ports.
 assumes it is bound into every scl_loader.
*/
`timescale 1ns/1ns
module scl_loader_assertions
   import scl_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // link pins
   input wire scl_pkg::scl_pins_type pins,
   // outputs and drain
   input wire scl_pkg::scl_word_type word_out,
   input wire logic word_strobe,
   input wire scl_pkg::scl_word_type q_data,
   input wire logic q_valid,
   input wire logic q_ready,
   input wire logic overflow,
   input wire logic frame_busy
);
   // ****
   // frame idle counter
   // ****
   logic [4:0] idle_r;
   logic [4:0] idle_nxt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // saturates so a long idle gap never wraps to look busy
   always_comb idle_nxt = pins.frame_select_n ? idle_r + {4'h0, idle_r != 5'h1F} : 5'h00;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) idle_r <= 5'h1F;
      else idle_r <= idle_nxt;
   end
   // ****
   // properties
   // ****
   strobe_once_a: assert property (word_strobe |=> !word_strobe [*8])
      else $error("strobe too long");
   strobe_fifo_a: assert property (word_strobe |=> q_valid)
      else $error("word not queued");
   word_hold_a: assert property ($changed(word_out) |-> word_strobe)
      else $error("word changed without strobe");
   strobe_frame_a: assert property (word_strobe |-> idle_r < 5'h0C)
      else $error("strobe outside frame");
   busy_idle_a: assert property (idle_r > 5'h0C |-> !frame_busy)
      else $error("busy after frame end");
   ovf_sticky_a: assert property (overflow |=> overflow)
      else $error("overflow cleared");
   ovf_full_a: assert property ($rose(overflow) |-> q_valid && (word_strobe || $past(word_strobe)))
      else $error("overflow without word");
   pop_only_a: assert property ($fell(q_valid) |-> $past(q_ready))
      else $error("queue lost without pop");
   head_hold_a: assert property (q_valid && !q_ready |=> q_valid && $stable(q_data))
      else $error("head moved while stalled");
   cover property (word_strobe);
   cover property ($rose(overflow));
   cover property ($fell(q_valid));
endmodule // scl_loader_assertions

bind scl_loader scl_loader_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.sys_clk(sys_clk), .rst(rst),
   .pins(pins), .word_out(word_out), .word_strobe(word_strobe), .q_data(q_data), .q_valid(q_valid),
   .q_ready(q_ready), .overflow(overflow), .frame_busy(frame_busy));

/* File: verif/tb.sv */
/*
 self-checking bench for scl_loader with a host model.
 assumes rtl, checker and host model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module tb;
   import scl_pkg::*;
   logic sys_clk;
   logic rst;
   logic q_ready;
   logic sk;
   logic fn;
   logic sd;
   scl_pins_type pins;
   scl_word_type word_out;
   scl_word_type q_data;
   logic word_strobe;
   logic q_valid;
   logic overflow;
   logic frame_busy;
   logic busy_prev;
   logic [15:0] sq[$];
   logic [15:0] fq[$];
   logic [15:0] e;
   int mismatches;
   int cmp_count;
   assign pins = {sk, fn, sd};
   scl_host_model i_host (.shift_clk(sk), .frame_select_n(fn), .serial_data_in(sd));
   scl_loader #(.FIFO_DEPTH(16)) i_dut (.sys_clk(sys_clk), .rst(rst), .pins(pins), .word_out(word_out),
      .word_strobe(word_strobe), .q_data(q_data), .q_valid(q_valid), .q_ready(q_ready),
      .overflow(overflow), .frame_busy(frame_busy));
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   // ****
   // tasks
   // ****
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // keep is low for a word that must be lost to a full queue
   task automatic send(input logic [15:0] w, input int nb, input int sp, input logic rl, input logic keep);
      if (nb >= 16) sq.push_back(w);
      if (nb >= 16 && keep) fq.push_back(w);
      i_host.xfer(w, nb, sp, rl);
      @(posedge sys_clk);
      #1;
   endtask
   // ****
   // monitor
   // ****
   // sampled mid-cycle, where registered outputs have settled
   always @(negedge sys_clk) begin
      if (!rst && word_strobe) begin
         e = (sq.size() > 0) ? sq.pop_front() : 16'hXXXX;
         `CHK(word_out, e)
         `CHK(word_out.ctrl, e[15:12])
         `CHK({word_out.addr, word_out.data}, e[11:0])
         `CHK(frame_busy, 1'h0)
         `CHK(busy_prev, 1'h1)
      end
      if (!rst && q_valid && q_ready) begin
         e = (fq.size() > 0) ? fq.pop_front() : 16'hXXXX;
         `CHK(q_data, e)
      end
      busy_prev = frame_busy;
   end
   initial begin
      #200000;
      mismatches++;
      summarize();
   end
   // ****
   // tests
   // ****
   initial begin
      rst = 1'h1;
      q_ready = 1'h1;
      void'($urandom(72));
      repeat (4) @(posedge sys_clk);
      #1 rst = 1'h0;
      for (int k = 0; k < 8; k++) send(16'($urandom), 16, 0, 1'($urandom), 1'h1);
      $display("test words done");
      for (int k = 0; k < 2; k++) send(16'($urandom), 16, 8, k[0], 1'h1);
      $display("test split done");
      send(16'hA5C3, 10, 0, 1'h1, 1'h1);
      send(16'h3C5A, 20, 0, 1'h1, 1'h1);
      $display("test frame length done");
      q_ready = 1'h0;
      // 16 fifo words plus the registered head hold 17 words
      for (int k = 0; k < 18; k++) begin
         if (k == 17) `CHK(overflow, 1'h0)
         send(16'($urandom), 16, 0, 1'h1, k < 17);
      end
      `CHK(overflow, 1'h1)
      for (int n = 0; n < 400 && fq.size() > 0; n++) begin
         q_ready = 1'($urandom);
         @(posedge sys_clk);
         #1;
      end
      `CHK(fq.size() == 0 && sq.size() == 0, 1'h1)
      $display("test fifo done");
      summarize();
   end
endmodule // tb
